// [common/irq_flags_map.svh]
// Purpose: Register offsets, field positions, reset values and timing counts for the request flag block
// Assumes: AXI4-Lite byte addressing, 8-bit registers in the low byte
// Notes: Offsets are the special function addresses used as byte addresses
`ifndef IRQ_FLAGS_MAP_SVH
`define IRQ_FLAGS_MAP_SVH
`define OFF_IRQ_ENABLE_A 8'ha8
`define OFF_IRQ_ENABLE_B 8'hb8
`define OFF_IRQ_REQUEST_CONTROL 8'hc0
`define OFF_TMR_CONTROL 8'h88
`define OFF_UART_CONTROL 8'h98
`define OFF_TMR2_CONTROL 8'hc8
`define OFF_ADC_CONTROL 8'hd8
`define OFF_ADC_REFERENCE 8'hda
`define OFF_ADC_RESULT 8'hd9
`define OFF_IRQ_PENDING 8'hf0
`define RST_BYTE 8'h00
`define ADC_CYC_BASE 6'd15
`define ADC_CYC_STEP 6'd7
`define BIT_EXT0_SEL 0
`define BIT_EXT0_FLAG 1
`define BIT_EXT1_SEL 2
`define BIT_EXT1_FLAG 3
`define BIT_TMR0_FLAG 5
`define BIT_TMR1_FLAG 7
`define BIT_RX_DONE 0
`define BIT_TX_DONE 1
`define BIT_EXT2_RISE 5
`define BIT_EXT3_RISE 6
`define BIT_RELOAD_EN 3
`define BIT_REPEAT 3
`define BIT_BUSY 4
`define BIT_GLOBAL_EN 7
`define VEC_STEP 8'h08
`define VEC_BASE_A 8'h03
`define VEC_BASE_B 8'h43
`endif

// [common/irq_flags_pkg.sv]
// Purpose: Types shared by the request flag block
// Assumes: Twelve sources in six pairs
// Notes: Source order follows the pair table, left side first
package irq_flags_pkg;
    typedef enum logic [3:0] {
        SRC_EXT0, SRC_TMR0, SRC_EXT1, SRC_TMR1, SRC_UART, SRC_TMR2,
        SRC_ADC, SRC_EXT2, SRC_EXT3, SRC_EXT4, SRC_EXT5, SRC_EXT6
    } irq_src_t;
    typedef struct packed {
        logic tmr0_overflow;
        logic tmr1_overflow;
        logic tmr2_overflow;
        logic tmr2_reload_edge;
        logic uart_rx_set;
        logic uart_tx_set;
        logic [3:0] compare_match;
    } irq_events_t;
    typedef struct packed {
        logic [7:0] data;
        logic done;
    } adc_result_t;
    typedef enum {
        ADC_IDLE, ADC_RUN
    } adc_state_t;
endpackage

// [src/adc_sequencer.sv]
// Purpose: Conversion sequencer timing a conversion and delivering its result
// Assumes: One machine cycle per aclk
// Notes: A restart during a conversion begins timing afresh
`timescale 1ns/1ps
`include "irq_flags_map.svh"
module adc_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [7:0] reference,
    input wire logic repeat_mode,
    input wire logic [7:0] sample,
    output irq_flags_pkg::adc_result_t result,
    output logic busy
);
    import irq_flags_pkg::*;
    adc_state_t state_q;
    logic [5:0] count_q;
    logic [5:0] length_q;
    logic [5:0] length_d;
    always_comb begin
        length_d = `ADC_CYC_BASE;
        if (reference[3:0] != 4'h0) begin
            length_d = length_d + `ADC_CYC_STEP;
        end
        if (reference[7:4] != 4'h0) begin
            length_d = length_d + `ADC_CYC_STEP;
        end
    end
    // Cycle 1 is the one after the start write; done lands in the final one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ADC_IDLE;
            count_q <= 6'h00;
            length_q <= `ADC_CYC_BASE;
            busy <= 1'b0;
            result <= '0;
        end else begin
            result.done <= 1'b0;
            if (start) begin
                state_q <= ADC_RUN;
                count_q <= 6'h00;
                length_q <= length_d;
                busy <= 1'b1;
            end else begin
                case (state_q)
                    ADC_IDLE: begin
                        count_q <= 6'h00;
                    end
                    ADC_RUN: begin
                        if (count_q + 6'h01 == length_q) begin
                            result.data <= sample;
                            result.done <= 1'b1;
                            count_q <= 6'h00;
                            busy <= repeat_mode;
                            state_q <= repeat_mode ? ADC_RUN : ADC_IDLE;
                        end else begin
                            count_q <= count_q + 6'h01;
                        end
                    end
                    default: state_q <= ADC_IDLE;
                endcase
            end
        end
    end
    conv_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        start |=> !result.done [*8]) else $error("Conversion ended too early");
    busy_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        start |=> busy) else $error("Busy not set after start");
    done_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        result.done && !repeat_mode && !$past(start) |-> !busy) else $error("Busy stays after done");
    conv_done_c: cover property (@(posedge aclk) disable iff (!aresetn) result.done);
endmodule

// [src/irq_request_flags.sv]
// Purpose: Interrupt request flags, enables and conversion-done flag behind an AXI4-Lite slave
// Assumes: aclk is the machine-cycle clock; pins are asynchronous and pass two flip-flops
// Notes: Priority resolution and vector fetch belong to the CPU; this block presents requests and vectors
// Summary of operation
// - Cycle 15, 22 or 29: store result, clear busy, flag
// - Continuous mode restarts on the next cycle
// - Twelve sources, six pairs, four priority levels
// - Each source owns a vector, 03h to 6bh
// - Ext0/ext1 level-low or falling-edge per select
// - Ext0/ext1 vector clear only in edge mode
// - Timer 0/1 overflow sets flag, vectoring clears it
// - Serial request is rx OR tx, software-cleared
// - Timer 2 request is overflow OR reload
// - Done after 15, 22 or 29 cycles
// - Ext2 selectable edge, cleared on vectoring
// - Ext3 selectable edge, cleared on vectoring
// - Compare channel 0 match also sets ext3
// - Ext4-6 rising edge or compare, vector clear
// - Software writes set or clear flags
// - Level mode ignores software one writes
// - Per-source enables plus one global enable
// - Second enable register sits at b8h
// - Request control at c0h, documented bit layout
// - Reload pin fall with enable and reload event sets reload flag
// - Timer 2 overflow flag held until cleared
// - Reference write starts conversion, busy at once
// - Repeat mode zero stops after one conversion
`timescale 1ns/1ps
`include "irq_flags_map.svh"
module irq_request_flags #(
    parameter int NUM_SRC = 12,
    parameter int NUM_LEVELS = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_pin_0_n,
    input wire logic ext_pin_1_n,
    input wire logic [6:2] ext_pin,
    input wire logic tmr2_reload_pin,
    input wire irq_flags_pkg::irq_events_t events,
    input wire logic [7:0] adc_sample,
    input wire logic [11:0] vector_ack,
    output logic [11:0] irq_request,
    output logic [7:0] irq_vector_base_a,
    output logic [7:0] irq_vector_base_b,
    output logic conv_busy_flag
);
    import irq_flags_pkg::*;
    if (NUM_SRC != 12 || NUM_LEVELS != 4) begin : g_param_check
        $error("Only twelve sources and four levels are supported");
    end

    // Two-flop pin synchronisers, then one history stage for edges
    logic [7:0] pin_m_q;
    logic [7:0] pin_s_q;
    logic [7:0] pin_h_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_m_q <= 8'hff;
            pin_s_q <= 8'hff;
            pin_h_q <= 8'hff;
        end else begin
            pin_m_q <= {tmr2_reload_pin, ext_pin, ext_pin_1_n, ext_pin_0_n};
            pin_s_q <= pin_m_q;
            pin_h_q <= pin_s_q;
        end
    end
    logic [7:0] rise;
    logic [7:0] fall;
    assign rise = pin_s_q & ~pin_h_q;
    assign fall = ~pin_s_q & pin_h_q;

    // Registers
    logic [7:0] irq_enable_a_q;
    logic [7:0] irq_enable_b_q;
    logic [7:0] irq_request_control_q;
    logic [7:0] tmr_control_q;
    logic [7:0] uart_control_q;
    logic [7:0] tmr2_control_q;
    logic [7:0] adc_control_q;
    logic [7:0] adc_reference_q;
    logic [7:0] adc_result_q;
    adc_result_t conv_q;
    logic conv_busy;

    // AXI4-Lite write path: address and data taken in either order
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_hit;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic [7:0] wr_byte;
    logic wr_en;
    assign wr_byte = w_data_q[7:0];
    assign wr_en = wr_fire && w_strb_q[0];
    always_comb begin
        if (aw_addr_q == `OFF_IRQ_ENABLE_A || aw_addr_q == `OFF_IRQ_ENABLE_B) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `OFF_IRQ_REQUEST_CONTROL || aw_addr_q == `OFF_TMR_CONTROL) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `OFF_UART_CONTROL || aw_addr_q == `OFF_TMR2_CONTROL) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `OFF_ADC_CONTROL || aw_addr_q == `OFF_ADC_REFERENCE) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `OFF_ADC_RESULT) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end
    function automatic logic wr_at(input logic [7:0] off);
        wr_at = wr_en && wr_hit && aw_addr_q == off;
    endfunction

    // Plain control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_a_q <= `RST_BYTE;
            irq_enable_b_q <= `RST_BYTE;
            tmr2_control_q <= `RST_BYTE;
            adc_reference_q <= `RST_BYTE;
        end else begin
            if (wr_at(`OFF_IRQ_ENABLE_A)) irq_enable_a_q <= wr_byte;
            if (wr_at(`OFF_IRQ_ENABLE_B)) irq_enable_b_q <= wr_byte;
            if (wr_at(`OFF_TMR2_CONTROL)) tmr2_control_q <= wr_byte;
            if (wr_at(`OFF_ADC_REFERENCE)) adc_reference_q <= wr_byte;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_control_q <= `RST_BYTE;
        end else if (wr_at(`OFF_ADC_CONTROL)) begin
            adc_control_q <= wr_byte & 8'hef;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_result_q <= `RST_BYTE;
        end else if (conv_q.done) begin
            adc_result_q <= conv_q.data;
        end else if (wr_at(`OFF_ADC_RESULT)) begin
            adc_result_q <= wr_byte;
        end
    end

    adc_sequencer u_adc (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(wr_at(`OFF_ADC_REFERENCE)),
        .reference(wr_byte),
        .repeat_mode(adc_control_q[`BIT_REPEAT]),
        .sample(adc_sample),
        .result(conv_q),
        .busy(conv_busy)
    );

    // Timer control: ext0/ext1 flags and timer 0/1 overflow flags
    logic lvl0;
    logic lvl1;
    assign lvl0 = !tmr_control_q[`BIT_EXT0_SEL];
    assign lvl1 = !tmr_control_q[`BIT_EXT1_SEL];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmr_control_q <= `RST_BYTE;
        end else begin
            if (wr_at(`OFF_TMR_CONTROL)) begin
                tmr_control_q <= wr_byte;
            end
            if (lvl0) begin
                tmr_control_q[`BIT_EXT0_FLAG] <= !pin_s_q[0];
            end else if (fall[0]) begin
                tmr_control_q[`BIT_EXT0_FLAG] <= 1'b1;
            end else if (vector_ack[SRC_EXT0]) begin
                tmr_control_q[`BIT_EXT0_FLAG] <= 1'b0;
            end
            if (lvl1) begin
                tmr_control_q[`BIT_EXT1_FLAG] <= !pin_s_q[1];
            end else if (fall[1]) begin
                tmr_control_q[`BIT_EXT1_FLAG] <= 1'b1;
            end else if (vector_ack[SRC_EXT1]) begin
                tmr_control_q[`BIT_EXT1_FLAG] <= 1'b0;
            end
            if (events.tmr0_overflow) begin
                tmr_control_q[`BIT_TMR0_FLAG] <= 1'b1;
            end else if (vector_ack[SRC_TMR0]) begin
                tmr_control_q[`BIT_TMR0_FLAG] <= 1'b0;
            end
            if (events.tmr1_overflow) begin
                tmr_control_q[`BIT_TMR1_FLAG] <= 1'b1;
            end else if (vector_ack[SRC_TMR1]) begin
                tmr_control_q[`BIT_TMR1_FLAG] <= 1'b0;
            end
        end
    end

    // Serial flags: set by the port, cleared only by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uart_control_q <= `RST_BYTE;
        end else begin
            if (wr_at(`OFF_UART_CONTROL)) begin
                uart_control_q <= wr_byte;
            end
            if (events.uart_rx_set) uart_control_q[`BIT_RX_DONE] <= 1'b1;
            if (events.uart_tx_set) uart_control_q[`BIT_TX_DONE] <= 1'b1;
        end
    end

    // Request control flags, hardware set wins over any clear
    logic [7:0] rc_set;
    logic [7:0] rc_ack;
    logic [7:0] rc_next;
    always_comb begin
        rc_set[0] = conv_q.done;
        rc_set[1] = tmr2_control_q[`BIT_EXT2_RISE] ? rise[2] : fall[2];
        rc_set[2] = (tmr2_control_q[`BIT_EXT3_RISE] ? rise[3] : fall[3]) || events.compare_match[0];
        rc_set[5:3] = rise[6:4] | events.compare_match[3:1];
        rc_set[6] = events.tmr2_overflow;
        rc_set[7] = fall[7] && tmr2_control_q[`BIT_RELOAD_EN] && events.tmr2_reload_edge;
        rc_ack = {2'b00, vector_ack[SRC_EXT6:SRC_EXT2], 1'b0};
        rc_next = irq_request_control_q & ~rc_ack;
        if (wr_at(`OFF_IRQ_REQUEST_CONTROL)) begin
            rc_next = wr_byte;
        end
        rc_next = rc_next | rc_set;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_request_control_q <= `RST_BYTE;
        end else begin
            irq_request_control_q <= rc_next;
        end
    end

    // Request outputs, gated by per-source and global enables
    logic [11:0] raw_req;
    logic [11:0] src_en;
    always_comb begin
        raw_req[SRC_EXT0] = tmr_control_q[`BIT_EXT0_FLAG];
        raw_req[SRC_TMR0] = tmr_control_q[`BIT_TMR0_FLAG];
        raw_req[SRC_EXT1] = tmr_control_q[`BIT_EXT1_FLAG];
        raw_req[SRC_TMR1] = tmr_control_q[`BIT_TMR1_FLAG];
        raw_req[SRC_UART] = |uart_control_q[1:0];
        raw_req[SRC_TMR2] = |irq_request_control_q[7:6];
        raw_req[SRC_EXT6:SRC_ADC] = irq_request_control_q[5:0];
        src_en = {irq_enable_b_q[5:0], irq_enable_a_q[5:0]};
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_request <= 12'h000;
        end else begin
            irq_request <= irq_enable_a_q[`BIT_GLOBAL_EN] ? (raw_req & src_en) : 12'h000;
        end
    end
    // Vector of pair n is base + 8n on each side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_vector_base_a <= `VEC_BASE_A;
            irq_vector_base_b <= `VEC_BASE_B;
            conv_busy_flag <= 1'b0;
        end else begin
            irq_vector_base_a <= `VEC_BASE_A;
            irq_vector_base_b <= `VEC_BASE_B;
            // Busy rises with the start write and falls with the done flag and result load
            conv_busy_flag <= wr_at(`OFF_ADC_REFERENCE) || (conv_q.done ? conv_busy : conv_busy_flag);
        end
    end

    // Read path
    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        if (s_axi_araddr == `OFF_IRQ_ENABLE_A) begin
            rd_byte = irq_enable_a_q;
        end else if (s_axi_araddr == `OFF_IRQ_ENABLE_B) begin
            rd_byte = irq_enable_b_q;
        end else if (s_axi_araddr == `OFF_IRQ_REQUEST_CONTROL) begin
            rd_byte = irq_request_control_q;
        end else if (s_axi_araddr == `OFF_TMR_CONTROL) begin
            rd_byte = tmr_control_q;
        end else if (s_axi_araddr == `OFF_UART_CONTROL) begin
            rd_byte = uart_control_q;
        end else if (s_axi_araddr == `OFF_TMR2_CONTROL) begin
            rd_byte = tmr2_control_q;
        end else if (s_axi_araddr == `OFF_ADC_CONTROL) begin
            rd_byte = adc_control_q | {3'b000, conv_busy_flag, 4'h0};
        end else if (s_axi_araddr == `OFF_ADC_REFERENCE) begin
            rd_byte = adc_reference_q;
        end else if (s_axi_araddr == `OFF_ADC_RESULT) begin
            rd_byte = adc_result_q;
        end else begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ext0_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !lvl0 && fall[0] |=> tmr_control_q[`BIT_EXT0_FLAG]) else $error("Ext0 edge lost");
    ext0_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        lvl0 && $stable(lvl0) |=> tmr_control_q[`BIT_EXT0_FLAG] == !$past(pin_s_q[0])) else $error("Ext0 level");
    tmr0_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        vector_ack[SRC_TMR0] && !events.tmr0_overflow && !wr_at(`OFF_TMR_CONTROL)
        |=> !tmr_control_q[`BIT_TMR0_FLAG]) else $error("Timer 0 flag not cleared");
    adc_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_q.done |=> irq_request_control_q[0] && adc_result_q == $past(conv_q.data)) else $error("Done lost");
    cmp0_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        events.compare_match[0] |=> irq_request_control_q[2]) else $error("Compare 0 lost");
    ovf2_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_request_control_q[6] && !wr_at(`OFF_IRQ_REQUEST_CONTROL) |=> irq_request_control_q[6])
        else $error("Timer 2 flag cleared by hardware");
    global_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !irq_enable_a_q[`BIT_GLOBAL_EN] |=> irq_request == 12'h000) else $error("Global disable ignored");
    sw_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_at(`OFF_IRQ_REQUEST_CONTROL) |=> (irq_request_control_q & $past(wr_byte)) == $past(wr_byte))
        else $error("Software set lost");
    adc_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_at(`OFF_ADC_REFERENCE) |=> conv_busy_flag) else $error("Busy not set by start");
    wr_c: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    rd_c: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
    req_c: cover property (@(posedge aclk) disable iff (!aresetn) irq_request[SRC_EXT3]);
endmodule

// [tb/cpu_vector_model.sv]
// Purpose: CPU vectoring model that acknowledges requests
// Assumes: One machine cycle per aclk
// Notes: Each request is acknowledged once as it rises while serving
`timescale 1ns/1ps
module cpu_vector_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serve,
    input wire logic [11:0] irq_request,
    output logic [11:0] vector_ack
);
    logic [11:0] seen_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !serve) begin
            seen_q <= '0;
            vector_ack <= '0;
        end else begin
            seen_q <= irq_request;
            vector_ack <= irq_request & ~seen_q;
        end
    end
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench for the request flag block
// Assumes: AXI4-Lite master driven on rising edges
// Notes: Pins idle high, events idle low
`timescale 1ns/1ps
`include "irq_flags_map.svh"
module testbench;
    import irq_flags_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, ext_pin_0_n = 1, ext_pin_1_n = 1, tmr2_reload_pin = 1;
    logic serve = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_busy_flag;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, adc_sample = 8'h5a, irq_vector_base_a, irq_vector_base_b;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [6:2] ext_pin = 5'h1f;
    irq_events_t events = '0;
    logic [11:0] vector_ack, irq_request;
    int error_cnt = 0, n_checks = 0;
    irq_request_flags dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_pin_0_n,
        .ext_pin_1_n, .ext_pin, .tmr2_reload_pin, .events, .adc_sample, .vector_ack, .irq_request,
        .irq_vector_base_a, .irq_vector_base_b, .conv_busy_flag);
    cpu_vector_model cpu (.aclk, .aresetn, .serve, .irq_request, .vector_ack);
    always #20 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task automatic t_reset;
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 0);
        chk(irq_vector_base_a, 8'h03);
        chk(irq_vector_base_b, 8'h43);
        rd_reg(8'h04);
        chk(rr, 2'h2);
    endtask
    task automatic t_soft;
        wr(`OFF_IRQ_ENABLE_B, 8'h3f);
        wr(`OFF_IRQ_ENABLE_A, 8'ha0);
        wr(`OFF_IRQ_REQUEST_CONTROL, 8'hfe);
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 32'hfe);
        repeat (3) @(posedge aclk);
        chk(irq_request, 12'hfa0);
        wr(`OFF_IRQ_ENABLE_A, 8'h20);
        repeat (3) @(posedge aclk);
        chk(irq_request, 0);
        wr(`OFF_IRQ_ENABLE_A, 8'ha0);
    endtask
    task automatic t_vector;
        wr(`OFF_IRQ_ENABLE_A, 8'ha2);
        serve <= 1;
        events.tmr0_overflow <= 1;
        @(posedge aclk);
        events <= '0;
        repeat (6) @(posedge aclk);
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 32'hc0);
        rd_reg(`OFF_TMR_CONTROL);
        chk(rd, 0);
        serve <= 0;
        wr(`OFF_IRQ_REQUEST_CONTROL, 8'h00);
    endtask
    task automatic t_edges;
        events.compare_match <= 4'h1;
        @(posedge aclk);
        events <= '0;
        ext_pin[4] <= 0;
        repeat (6) @(posedge aclk);
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 32'h04);
        ext_pin[4] <= 1;
        repeat (6) @(posedge aclk);
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 32'h0c);
        wr(`OFF_TMR_CONTROL, 8'h01);
        ext_pin_0_n <= 0;
        repeat (6) @(posedge aclk);
        ext_pin_0_n <= 1;
        rd_reg(`OFF_TMR_CONTROL);
        chk(rd, 32'h03);
        wr(`OFF_TMR_CONTROL, 8'h00);
        wr(`OFF_IRQ_REQUEST_CONTROL, 8'h00);
    endtask
    task automatic t_adc;
        wr(`OFF_ADC_REFERENCE, 8'h00);
        repeat (2) @(posedge aclk);
        chk(conv_busy_flag, 1);
        repeat (30) @(posedge aclk);
        chk(conv_busy_flag, 0);
        rd_reg(`OFF_ADC_RESULT);
        chk(rd, 32'h5a);
        wr(`OFF_IRQ_REQUEST_CONTROL, 8'h00);
        adc_sample <= 8'h3c;
        wr(`OFF_ADC_REFERENCE, 8'h11);
        repeat (20) @(posedge aclk);
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 0);
        repeat (10) @(posedge aclk);
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 32'h01);
        rd_reg(`OFF_ADC_RESULT);
        chk(rd, 32'h3c);
        wr(`OFF_ADC_CONTROL, 8'h08);
        wr(`OFF_ADC_REFERENCE, 8'h00);
        repeat (40) @(posedge aclk);
        chk(conv_busy_flag, 1);
        wr(`OFF_IRQ_REQUEST_CONTROL, 8'h00);
        repeat (20) @(posedge aclk);
        rd_reg(`OFF_IRQ_REQUEST_CONTROL);
        chk(rd, 32'h01);
        wr(`OFF_ADC_CONTROL, 8'h00);
        repeat (20) @(posedge aclk);
        chk(conv_busy_flag, 0);
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_soft();
        t_vector();
        t_edges();
        t_adc();
        close_out();
    end
endmodule
